// *** logic/pwm_pkg.sv ***
// Purpose: Shared constants and types of the timer based PWM output.
// Assumes: APB with 32-bit data, byte addresses, one aligned word per register.
// Notes:   The register offsets and field positions are kept here only.
package pwm_pkg;

    // Datapath widths
    localparam int TIMER_W   = 8;
    localparam int LOW_W     = 2;
    localparam int TB_W      = TIMER_W + LOW_W;
    localparam int PRESC_W   = 6;
    localparam int PHASE_W   = 2;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;

    // Oscillator period in ns and oscillator phases per timer cycle
    localparam int OSC_PERIOD_NS    = 10;
    localparam int PHASES_PER_CYCLE = 4;
    localparam logic [PHASE_W-1:0] LAST_PHASE = PHASE_W'(PHASES_PER_CYCLE - 1);

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL        = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PERIOD      = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_DUTY_STAGE  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DUTY_ACTIVE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_TIMER       = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS      = 8'h14;

    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_PS_LSB = 1;
    localparam int CTRL_DC_LSB = 4;

    // Status register fields
    localparam int STAT_PIN_BIT = 0;
    localparam int STAT_EN_BIT  = 1;
    localparam int STAT_LAT_LSB = 2;

    // Reset values
    localparam logic [TIMER_W-1:0] RST_PERIOD = 8'hff;
    localparam logic [TIMER_W-1:0] RST_DUTY   = 8'h00;
    localparam logic [LOW_W-1:0]   RST_LOW    = 2'h0;

    // Prescale ratios of the period timer
    typedef enum logic [1:0] {
        PS_1  = 2'h0,
        PS_4  = 2'h1,
        PS_16 = 2'h2,
        PS_64 = 2'h3
    } presc_sel_t;

endpackage

// *** logic/timebase_gen.sv ***
// Purpose: Oscillator phase and prescaler counters feeding the PWM time base.
// Assumes: One oscillator phase per pclk edge; counters idle while disabled.
// Notes:   Gives the timer increment pulse and the two low time base bits.
`timescale 1ns/1ps
module timebase_gen
    import pwm_pkg::*;
(
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Control
    input  wire logic               en,
    input  wire presc_sel_t         ps_sel,
    // Time base outputs
    output logic                    tick_inc,
    output logic [LOW_W-1:0]        low2
);

    logic [PHASE_W-1:0] phase_r;
    logic [PRESC_W-1:0] presc_r;
    logic               tcy;

    // Last prescaler count before the timer steps
    function automatic logic [PRESC_W-1:0] presc_limit(input presc_sel_t s);
        case (s)
            PS_1:    presc_limit = 6'h00;
            PS_4:    presc_limit = 6'h03;
            PS_16:   presc_limit = 6'h0f;
            PS_64:   presc_limit = 6'h3f;
            default: presc_limit = 6'h00;
        endcase
    endfunction

    assign tcy = (phase_r == LAST_PHASE);
    // No postscaler anywhere in this path
    assign tick_inc = tcy && (presc_r == presc_limit(ps_sel));

    // Oscillator phase, held at zero while disabled so a new run starts clean
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= 2'h0;
        end else if (!en) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // Prescaler counts timer cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_r <= 6'h00;
        end else if (!en || tick_inc) begin
            presc_r <= 6'h00;
        end else if (tcy) begin
            presc_r <= presc_r + 6'h01;
        end
    end

    // Low bits: clock phase at 1:1, top prescaler bits otherwise
    always_comb begin
        case (ps_sel)
            PS_1:    low2 = phase_r;
            PS_4:    low2 = presc_r[1:0];
            PS_16:   low2 = presc_r[3:2];
            PS_64:   low2 = presc_r[5:4];
            default: low2 = phase_r;
        endcase
    end

    a_low_phase: assert property (@(posedge pclk) disable iff (!presetn)
        (en && ps_sel == PS_1) |=> (!en || ps_sel != PS_1 || low2 == $past(low2) + 2'h1))
        else $error("low bits not stepping with clock phase at 1:1");

    a_low_presc: assert property (@(posedge pclk) disable iff (!presetn)
        (en && ps_sel == PS_4 && !tcy) |=> (!en || ps_sel != PS_4 || $stable(low2)))
        else $error("low bits moved between timer cycles at 1:4");

    a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        (en && ps_sel == PS_1 && $stable(ps_sel) && tick_inc) |=> !tick_inc [*3])
        else $error("timer stepped faster than one per four phases");

endmodule

// *** logic/timer_based_pwm_output.sv ***
// Purpose: PWM generator with period timer, period compare and double
//          buffered 10-bit duty, reached over an APB slave.
// Assumes: pclk is the oscillator; APB signals are synchronous to pclk.
// Notes:   Zero wait state slave; read data registered in the setup cycle.
`timescale 1ns/1ps
module timer_based_pwm_output
    import pwm_pkg::*;
(
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [DATA_W-1:0]  pwdata,
    output logic [DATA_W-1:0]       prdata,
    output logic                    pready,
    output logic                    pslverr,
    // PWM pin
    output logic                    pwm_output_pin
);

    // Software visible state
    logic                 en_r;
    presc_sel_t           ps_r;
    logic [LOW_W-1:0]     duty_low_bits_r;
    logic [TIMER_W-1:0]   period_value_r;
    logic [TIMER_W-1:0]   duty_staging_reg_r;
    logic [TIMER_W-1:0]   duty_active_reg_r;
    logic [LOW_W-1:0]     duty_latch_r;

    // Time base state
    logic [TIMER_W-1:0]   period_timer_r;
    logic                 pin_r;
    logic                 tick_inc;
    logic [LOW_W-1:0]     low2;
    logic [TB_W-1:0]      time_base;
    logic [TB_W-1:0]      duty_cmp;
    logic [TB_W-1:0]      duty_stage_val;
    logic                 period_match;
    logic                 duty_match;
    logic                 set_pend_r;

    // Bus state
    logic [DATA_W-1:0]    rdata_r;
    logic                 err_r;
    logic                 setup;
    logic                 access;
    logic                 wr_ok;

    // Address decode, evaluated in the setup phase only; access uses the registered result
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        case (a)
            OFF_CTRL, OFF_PERIOD, OFF_DUTY_STAGE,
            OFF_DUTY_ACTIVE, OFF_TIMER, OFF_STATUS: addr_ok = 1'b1;
            default:                                addr_ok = 1'b0;
        endcase
    endfunction

    //--------------------------------------------------------------
    // Phase and prescaler counters
    //--------------------------------------------------------------

    timebase_gen u_timebase (
        .pclk     (pclk),
        .presetn  (presetn),
        .en       (en_r),
        .ps_sel   (ps_r),
        .tick_inc (tick_inc),
        .low2     (low2)
    );

    //--------------------------------------------------------------
    // Compares
    //--------------------------------------------------------------

    // 10-bit time base: timer count over the two low bits
    assign time_base = {period_timer_r, low2};

    // Active compare value: upper byte plus the internal latch
    assign duty_cmp = {duty_active_reg_r, duty_latch_r};

    // Value about to be latched; high byte from staging, low from control
    assign duty_stage_val = {duty_staging_reg_r, duty_low_bits_r};

    // Period match acts only on an increment edge, no postscaler
    assign period_match = en_r && tick_inc
                        && (period_timer_r == period_value_r);

    // Duty match evaluated every clock; the time base steps every clock only at 1:1,
    // so the compare result lasts one clock there and several clocks at slower prescales
    assign duty_match = en_r && (time_base == duty_cmp);

    //--------------------------------------------------------------
    // Period timer
    //--------------------------------------------------------------

    // Counts per increment and wraps on period match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_timer_r <= '0;
        end else if (!en_r) begin
            period_timer_r <= '0;
        end else if (period_match) begin
            period_timer_r <= '0;
        end else if (tick_inc) begin
            period_timer_r <= period_timer_r + 8'h01;
        end
    end

    //--------------------------------------------------------------
    // Duty double buffer
    //--------------------------------------------------------------

    // Active byte; software may load it only while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_active_reg_r <= RST_DUTY;
        end else if (period_match) begin
            duty_active_reg_r <= duty_staging_reg_r;
        end else if (wr_ok && !en_r && paddr == OFF_DUTY_ACTIVE) begin
            duty_active_reg_r <= pwdata[TIMER_W-1:0];
        end
    end

    // Low latch, readable only in status, loaded with the active byte so no glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_latch_r <= RST_LOW;
        end else if (period_match) begin
            duty_latch_r <= duty_low_bits_r;
        end
    end

    //--------------------------------------------------------------
    // Output pin
    //--------------------------------------------------------------

    // Set lands one clock after the match, mirroring the clock that a
    // duty compare takes to clear, so the pulse spans exactly duty steps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set_pend_r <= 1'b0;
        end else begin
            set_pend_r <= period_match;
        end
    end

    // Duty match has priority so a coincident set never leaves a spike;
    // with no match at all the pin simply holds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_r <= 1'b0;
        end else if (!en_r) begin
            pin_r <= 1'b0;
        end else if (duty_match) begin
            pin_r <= 1'b0;
        end else if (set_pend_r && duty_cmp != '0) begin
            pin_r <= 1'b1;
        end
        // Otherwise unchanged, also when duty exceeds period
    end

    assign pwm_output_pin = pin_r;

    //--------------------------------------------------------------
    // APB slave
    //--------------------------------------------------------------

    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign wr_ok  = access && pwrite && !err_r;

    // Always ready: every transfer is setup plus one access cycle
    assign pready  = 1'b1;
    assign pslverr = access && err_r;

    // Decode captured in setup; address is stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_r <= 1'b0;
        end else if (setup) begin
            err_r <= !addr_ok(paddr);
        end
    end

    // Read data captured in setup so prdata comes from a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= '0;
        end else if (setup && !pwrite) begin
            rdata_r <= '0;
            case (paddr)
                OFF_CTRL: begin
                    rdata_r[CTRL_EN_BIT]                 <= en_r;
                    rdata_r[CTRL_PS_LSB +: 2]            <= ps_r;
                    rdata_r[CTRL_DC_LSB +: LOW_W]        <= duty_low_bits_r;
                end
                OFF_PERIOD:      rdata_r[TIMER_W-1:0] <= period_value_r;
                OFF_DUTY_STAGE:  rdata_r[TIMER_W-1:0] <= duty_staging_reg_r;
                OFF_DUTY_ACTIVE: rdata_r[TIMER_W-1:0] <= duty_active_reg_r;
                OFF_TIMER:       rdata_r[TIMER_W-1:0] <= period_timer_r;
                OFF_STATUS: begin
                    rdata_r[STAT_PIN_BIT]                <= pin_r;
                    rdata_r[STAT_EN_BIT]                 <= en_r;
                    rdata_r[STAT_LAT_LSB +: LOW_W]       <= duty_latch_r;
                end
                default:         rdata_r <= '0;
            endcase
        end
    end

    assign prdata = rdata_r;

    // Control: enable, prescale and the low duty bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r            <= 1'b0;
            ps_r            <= PS_1;
            duty_low_bits_r <= RST_LOW;
        end else if (wr_ok && paddr == OFF_CTRL) begin
            en_r            <= pwdata[CTRL_EN_BIT];
            ps_r            <= presc_sel_t'(pwdata[CTRL_PS_LSB +: 2]);
            duty_low_bits_r <= pwdata[CTRL_DC_LSB +: LOW_W];
        end
    end

    // Period value; a change mid-period takes hold at the next compare
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_value_r <= RST_PERIOD;
        end else if (wr_ok && paddr == OFF_PERIOD) begin
            period_value_r <= pwdata[TIMER_W-1:0];
        end
    end

    // Staging byte written freely; output sees it only at period match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_staging_reg_r <= RST_DUTY;
        end else if (wr_ok && paddr == OFF_DUTY_STAGE) begin
            duty_staging_reg_r <= pwdata[TIMER_W-1:0];
        end
    end

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_timer_clear: assert property (
        period_match |=> (period_timer_r == 8'h00))
        else $error("period timer not cleared after period match");

    a_pin_set: assert property (
        (period_match && duty_stage_val != '0) ##1 (en_r && !duty_match) |=> pin_r)
        else $error("pin not set at period match");

    a_zero_duty: assert property (
        (period_match && duty_stage_val == '0) |=> ##1 !pin_r)
        else $error("pin set with zero duty");

    a_duty_latch: assert property (
        period_match |=> (duty_cmp == $past(duty_stage_val)))
        else $error("duty not latched at period match");

    a_duty_hold: assert property (
        (en_r && !period_match) |=> $stable(duty_cmp))
        else $error("active duty changed outside a period match");

    a_active_ro: assert property (
        (en_r && access && pwrite && paddr == OFF_DUTY_ACTIVE && !period_match)
        |=> $stable(duty_active_reg_r))
        else $error("active duty written while running");

    a_duty_clear: assert property (
        duty_match |=> !pin_r)
        else $error("pin not cleared on duty match");

    a_both_low: assert property (
        (duty_match && period_match) |=> (!pin_r && period_timer_r == 8'h00))
        else $error("coincident matches did not leave pin low");

    a_pin_hold: assert property (
        (en_r && !duty_match && !set_pend_r) |=> (pin_r == $past(pin_r)))
        else $error("pin changed without a match");

    a_timer_step: assert property (
        (en_r && tick_inc && !period_match)
        |=> (period_timer_r == $past(period_timer_r) + 8'h01))
        else $error("period timer did not step on increment");

endmodule

// *** verification/timer_based_pwm_output_test.sv ***
// Purpose: Self-checking bench for the timer based PWM output.
// Assumes: Zero-wait APB slave; pclk is the oscillator, one phase per edge.
// Notes:   Reads and pulse width counts go through one queue of expected values.
`timescale 1ns/1ps
module timer_based_pwm_output_test;
    import pwm_pkg::*;

    logic               pclk;
    logic               presetn;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [ADDR_W-1:0]  paddr;
    logic [DATA_W-1:0]  pwdata;
    logic [DATA_W-1:0]  prdata;
    logic               pready;
    logic               pslverr;
    logic               pwm_output_pin;
    logic [32:0]        exp_q[$];
    logic               meas_done;
    logic [31:0]        meas_val;
    int                 fail_count;
    int                 comparisons;
    int                 cases[7][3];

    // Free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    timer_based_pwm_output dut (
        .pclk           (pclk),
        .presetn        (presetn),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .pwm_output_pin (pwm_output_pin)
    );

    // Single exit point of the run
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Oldest note against the result that just appeared
    task automatic check(input logic [32:0] got);
        logic [32:0] e;
        e = exp_q.pop_front();
        comparisons++;
        if (got !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t expected %h got %h", $time, e, got);
        end
    endtask

    // Watcher: read data with error flag, and pulse width counts
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            check({pslverr, prdata});
        end
        if (meas_done === 1'b1) begin
            check({1'b0, meas_val});
        end
    end

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait count assumed; a hang is left to the watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic err);
        exp_q.push_back({err, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // Count high cycles over exactly one period
    task automatic measure(input int e, input int len);
        int cnt;
        exp_q.push_back({1'b0, 32'(e)});
        cnt = 0;
        repeat (len) begin
            @(posedge pclk);
            if (pwm_output_pin === 1'b1) cnt++;
        end
        meas_val  <= 32'(cnt);
        meas_done <= 1'b1;
        @(posedge pclk);
        meas_done <= 1'b0;
    endtask

    // Programme a setting, let two periods settle the buffers, then measure
    task automatic run_case(input int ps, input int p, input int d);
        int n;
        int per;
        int e;
        n   = 1 << (2 * ps);
        per = 4 * (p + 1) * n;
        e   = (d < 4 * (p + 1)) ? d * n : per;
        wr(OFF_CTRL, 32'h0000_0000);
        wr(OFF_PERIOD, 32'(p));
        wr(OFF_DUTY_STAGE, 32'(d >> 2));
        wr(OFF_CTRL, 32'(1 | (ps << 1) | ((d & 3) << 4)));
        repeat (2 * per + 8) @(posedge pclk);
        measure(e, per);
    endtask

    // Hang guard, well beyond the expected run length
    initial begin
        #600000;
        fail_count++;
        give_verdict();
    end

    // Main sequence
    initial begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0000_0000;
        meas_done   = 1'b0;
        meas_val    = 32'h0000_0000;
        fail_count  = 0;
        comparisons = 0;
        cases = '{'{0, 255, 1023}, '{0, 3, 0}, '{0, 3, 20}, '{0, 3, 16},
                  '{1, 5, 13}, '{2, 2, 7}, '{3, 1, 5}};
        void'($urandom(24136));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and refused accesses
        rd(OFF_CTRL, 32'h0000_0000, 1'b0);
        rd(OFF_PERIOD, 32'h0000_00ff, 1'b0);
        rd(OFF_DUTY_STAGE, 32'h0000_0000, 1'b0);
        rd(OFF_DUTY_ACTIVE, 32'h0000_0000, 1'b0);
        rd(OFF_STATUS, 32'h0000_0000, 1'b0);
        rd(8'h18, 32'h0000_0000, 1'b1);
        wr(OFF_TIMER, 32'h0000_0077);
        rd(OFF_TIMER, 32'h0000_0000, 1'b0);
        wr(OFF_DUTY_ACTIVE, 32'h0000_005a);
        rd(OFF_DUTY_ACTIVE, 32'h0000_005a, 1'b0);
        // Staged writes wait for the period match; 1:64 keeps it far off
        wr(OFF_PERIOD, 32'h0000_0003);
        wr(OFF_DUTY_STAGE, 32'h0000_005a);
        wr(OFF_CTRL, 32'h0000_0027);
        wr(OFF_DUTY_STAGE, 32'h0000_000c);
        wr(OFF_CTRL, 32'h0000_0017);
        wr(OFF_DUTY_ACTIVE, 32'h0000_0033);
        rd(OFF_DUTY_ACTIVE, 32'h0000_005a, 1'b0);
        repeat (1100) @(posedge pclk);
        rd(OFF_DUTY_ACTIVE, 32'h0000_000c, 1'b0);
        rd(OFF_STATUS, 32'h0000_0007, 1'b0);
        // Fixed table over every prescale, then random settings
        for (int i = 0; i < 7; i++) begin
            run_case(cases[i][0], cases[i][1], cases[i][2]);
        end
        for (int i = 0; i < 4; i++) begin
            int ps;
            int p;
            int d;
            ps = int'($urandom % 4);
            p  = int'($urandom % 8);
            d  = int'($urandom % (4 * (p + 1) + 4));
            run_case(ps, p, d);
        end
        give_verdict();
    end

endmodule
